// [hw/pwr_seq_pkg.sv]
// Functional notes
// (RULE_01) Release internal reset only with supply above threshold and chip enable high.
// (RULE_02) Sample test-mode strap within 4 ms of release; low selects test mode.
// (RULE_03) Sample supply-option strap within 4 ms of release; high means option 1.
// (RULE_04) Start core power after release; ready after 4.5 ms or 6 ms.
// (RULE_05) Sample download-disable strap within 5 ms of core power; low selects download.
// (RULE_06) Debounce chip enable as reset input, programmable from 0 us to 16 ms.
// (RULE_07) Reset source holds chip enable low 0.1 ms beyond debounce, plus margin.
// (RULE_08) Temperature above high threshold raises an interrupt.
// (RULE_09) Temperature crossing below low threshold raises an interrupt.
// (RULE_10) Temperature above protection threshold powers down in hardware.
// (RULE_11) Thermal and protection enable writes pass a write-access lock.
// (RULE_12) Strap values latched once per reset cycle and held until next reset.
package pwr_seq_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_MHZ = 10;
   localparam int TEST_STRAP_WINDOW_US = 4000;
   localparam int SUPPLY_STRAP_WINDOW_US = 4000;
   localparam int DOWNLOAD_STRAP_WINDOW_US = 5000;
   localparam int STRAP_SAMPLE_US = 10;
   localparam int CORE_OPT1_US = 4500;
   localparam int CORE_OPT2_US = 6000;
   localparam int DEBOUNCE_STEP_US = 1000;
   localparam int CORE_OPT1_CYC = CORE_OPT1_US * CLK_MHZ;
   localparam int CORE_OPT2_CYC = CORE_OPT2_US * CLK_MHZ;
   localparam int DEBOUNCE_STEP_CYC = DEBOUNCE_STEP_US * CLK_MHZ;
   localparam int CNT_W = 18;
   localparam logic [CNT_W-1:0] STRAP_SAMPLE_CYC = CNT_W'(STRAP_SAMPLE_US * CLK_MHZ);

   // ==========================================================
   // Register map
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_KEY = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_DEBOUNCE = 12'h008;
   localparam logic [ADDR_W-1:0] OFS_THR_HIGH = 12'h00C;
   localparam logic [ADDR_W-1:0] OFS_THR_LOW = 12'h010;
   localparam logic [ADDR_W-1:0] OFS_THR_OTP = 12'h014;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h018;
   localparam logic [ADDR_W-1:0] OFS_INT_STAT = 12'h01C;
   localparam logic [ADDR_W-1:0] OFS_INT_MASK = 12'h020;

   localparam int CTRL_THERM_EN = 0;
   localparam int CTRL_OTP_EN = 1;
   localparam logic [7:0] UNLOCK_KEY = 8'h5A;
   localparam int DEB_CODE_W = 5;
   localparam logic [DEB_CODE_W-1:0] DEB_CODE_MAX = 5'h10;
   localparam int TEMP_W = 8;
   localparam logic [TEMP_W-1:0] THR_HIGH_RST = 8'hFF;
   localparam logic [TEMP_W-1:0] THR_LOW_RST = 8'h00;
   localparam logic [TEMP_W-1:0] THR_OTP_RST = 8'hFF;
   localparam int INT_W = 3;
   localparam int INT_HIGH = 0;
   localparam int INT_LOW = 1;
   localparam int INT_OTP = 2;
   localparam int STAT_TEMP_LSB = 8;

   typedef enum logic [2:0] {
      ST_RESET,
      ST_STRAP,
      ST_CORE_UP,
      ST_DL_STRAP,
      ST_RUN,
      ST_OTP_OFF
   } seq_state_t;
endpackage : pwr_seq_pkg

// [hw/deb_if.sv]
`timescale 1ns/1ps
interface deb_if;
   import pwr_seq_pkg::*;
   logic en_level;
   logic [DEB_CODE_W-1:0] code;
   logic held_low;
   modport ctl (output en_level, output code, input held_low);
   modport deb (input en_level, input code, output held_low);
endinterface : deb_if

// [hw/chip_en_debouncer.sv]
`timescale 1ns/1ps
module chip_en_debouncer
   import pwr_seq_pkg::*;
#(
   parameter int STEP_CYC = DEBOUNCE_STEP_CYC
)
(
   input wire logic core_clk,
   input wire logic rst_b,
   deb_if.deb d
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic held_low;
   } deb_state_t;

   deb_state_t s_q;
   deb_state_t s_d;
   logic [CNT_W-1:0] target;

   function automatic logic [CNT_W-1:0] hold_cycles(input logic [DEB_CODE_W-1:0] code);
      hold_cycles = CNT_W'(32'(code) * STEP_CYC);
   endfunction : hold_cycles

   assign target = hold_cycles(d.code);
   assign d.held_low = s_q.held_low;

   // ==========================================================
   // Low level must persist for the whole programmed time
   always_comb
   begin
      s_d = s_q;
      if (d.en_level)
      begin
         s_d.cnt = '0;
         s_d.held_low = 1'b0;
      end
      else if (s_q.cnt >= target)
         s_d.held_low = 1'b1; // RULE_06
      else
         s_d.cnt = s_q.cnt + 1'b1;
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   property p_deb_wait;
      $rose(d.held_low) |-> ($past(s_q.cnt) >= $past(target)) && !$past(d.en_level);
   endproperty
   a_deb_wait: assert property (p_deb_wait) else $error("reset taken before debounce time"); // RULE_06

   property p_deb_release;
      d.en_level |=> !d.held_low;
   endproperty
   a_deb_release: assert property (p_deb_release) else $error("debounced reset stuck"); // RULE_06
endmodule : chip_en_debouncer

// [hw/power_on_reset_boot_straps.sv]
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module power_on_reset_boot_straps
   import pwr_seq_pkg::*;
#(
   parameter int CORE1_CYC = CORE_OPT1_CYC,
   parameter int CORE2_CYC = CORE_OPT2_CYC,
   parameter int DEB_STEP_CYC = DEBOUNCE_STEP_CYC
)
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic supply_above_por,
   input wire logic chip_en,
   input wire logic test_mode_strap,
   input wire logic supply_option_strap,
   input wire logic download_disable_strap,
   input wire logic [TEMP_W-1:0] temp_code,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   output logic sys_rst_b,
   output logic core_pwr_en,
   output logic test_mode,
   output logic supply_opt1,
   output logic download_boot,
   output logic boot_done,
   output logic otp_shutdown
);
   typedef struct packed {
      logic [1:0] por_s;
      logic [1:0] en_s;
      logic [2:0] strap_s1;
      logic [2:0] strap_s2;
      logic [TEMP_W-1:0] temp_s1;
      logic [TEMP_W-1:0] temp_s2;
      logic [TEMP_W-1:0] temp_s3, temp_q;
      seq_state_t st;
      logic [CNT_W-1:0] cnt;
      logic sys_rst_b;
      logic core_pwr_en;
      logic straps_valid;
      logic test_mode;
      logic supply_opt1;
      logic download_boot;
      logic boot_done;
      logic otp_shutdown;
      logic therm_en;
      logic otp_en;
      logic unlocked;
      logic [DEB_CODE_W-1:0] deb_code;
      logic [TEMP_W-1:0] thr_high;
      logic [TEMP_W-1:0] thr_low;
      logic [TEMP_W-1:0] thr_otp;
      logic hi_prev;
      logic lo_prev;
      logic [INT_W-1:0] int_stat;
      logic [INT_W-1:0] int_mask;
      logic irq;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } regs_t;

   regs_t s_q;
   regs_t s_d;
   deb_if deb_bus ();

   logic por_ok;
   logic en_ok;
   logic go_reset;
   logic hi_now;
   logic lo_now;
   logic otp_now;
   logic setup;
   logic wr;
   logic [INT_W-1:0] ev;
   logic [CNT_W-1:0] core_last;
   logic [31:0] rdv;

   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      is_mapped = (a == OFS_CTRL) || (a == OFS_KEY) || (a == OFS_DEBOUNCE) ||
                  (a == OFS_THR_HIGH) || (a == OFS_THR_LOW) || (a == OFS_THR_OTP) ||
                  (a == OFS_STATUS) || (a == OFS_INT_STAT) || (a == OFS_INT_MASK);
   endfunction : is_mapped

   chip_en_debouncer #(
      .STEP_CYC(DEB_STEP_CYC)
   ) u_deb (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .d(deb_bus.deb)
   );

   assign deb_bus.en_level = s_q.en_s[1];
   assign deb_bus.code = s_q.deb_code;

   // ==========================================================
   // Supply and enable qualification
   assign por_ok = s_q.por_s[1];
   assign en_ok = s_q.en_s[1];
   // Either order of arrival works; only the joint level matters
   assign go_reset = !por_ok || deb_bus.held_low;
   assign core_last = s_q.supply_opt1 ? CNT_W'(CORE1_CYC - 1) : CNT_W'(CORE2_CYC - 1);

   // Thermal comparisons are gated off while the sensor is disabled
   assign hi_now = s_q.therm_en && (s_q.temp_q > s_q.thr_high);
   assign lo_now = s_q.therm_en && (s_q.temp_q < s_q.thr_low);
   assign otp_now = s_q.therm_en && s_q.otp_en && (s_q.temp_q > s_q.thr_otp) &&
                    (s_q.st != ST_RESET) && (s_q.st != ST_OTP_OFF) && !go_reset;

   assign setup = psel && penable && !s_q.pready;
   assign wr = psel && penable && s_q.pready && pwrite;

   always_comb
   begin
      case (paddr)
         OFS_CTRL: rdv = {30'h0, s_q.otp_en, s_q.therm_en};
         OFS_KEY: rdv = {31'h0, s_q.unlocked};
         OFS_DEBOUNCE: rdv = {27'h0, s_q.deb_code};
         OFS_THR_HIGH: rdv = {24'h0, s_q.thr_high};
         OFS_THR_LOW: rdv = {24'h0, s_q.thr_low};
         OFS_THR_OTP: rdv = {24'h0, s_q.thr_otp};
         OFS_STATUS: rdv = {16'h0, s_q.temp_q, s_q.boot_done, s_q.st, s_q.otp_shutdown,
                            s_q.download_boot, s_q.supply_opt1, s_q.test_mode};
         OFS_INT_STAT: rdv = {29'h0, s_q.int_stat};
         OFS_INT_MASK: rdv = {29'h0, s_q.int_mask};
         default: rdv = '0;
      endcase
   end

   // ==========================================================
   // Next state
   always_comb
   begin
      s_d = s_q;
      s_d.por_s = {s_q.por_s[0], supply_above_por};
      s_d.en_s = {s_q.en_s[0], chip_en};
      s_d.strap_s1 = {download_disable_strap, supply_option_strap, test_mode_strap};
      s_d.strap_s2 = s_q.strap_s1;
      s_d.temp_s1 = temp_code;
      s_d.temp_s2 = s_q.temp_s1;
      s_d.temp_s3 = s_q.temp_s2;
      s_d.temp_q = (s_q.temp_s2 == s_q.temp_s3) ? s_q.temp_s2 : s_q.temp_q;
      s_d.cnt = s_q.cnt + 1'b1;

      case (s_q.st)
         ST_RESET:
         begin
            s_d.cnt = '0;
            if (por_ok && en_ok && !go_reset)
            begin
               s_d.st = ST_STRAP;
               s_d.sys_rst_b = 1'b1; // RULE_01
            end
         end
         ST_STRAP:
         begin
            if (s_q.cnt == STRAP_SAMPLE_CYC - 1'b1)
            begin
               s_d.test_mode = !s_q.strap_s2[0]; // RULE_02
               s_d.supply_opt1 = s_q.strap_s2[1]; // RULE_03
               s_d.straps_valid = 1'b1; // RULE_12
               s_d.core_pwr_en = 1'b1; // RULE_04
               s_d.cnt = '0;
               s_d.st = ST_CORE_UP;
            end
         end
         ST_CORE_UP:
         begin
            if (s_q.cnt == core_last)
            begin
               s_d.cnt = '0;
               s_d.st = ST_DL_STRAP; // RULE_04
            end
         end
         ST_DL_STRAP:
         begin
            if (s_q.cnt == STRAP_SAMPLE_CYC - 1'b1)
            begin
               s_d.download_boot = !s_q.strap_s2[2]; // RULE_05
               s_d.boot_done = 1'b1;
               s_d.st = ST_RUN;
            end
         end
         ST_RUN, ST_OTP_OFF:
            s_d.cnt = s_q.cnt;
         default:
            s_d.st = ST_RESET;
      endcase

      // Protection shutdown holds until a full reset cycle; software cannot undo it
      if (otp_now)
      begin
         s_d.st = ST_OTP_OFF; // RULE_10
         s_d.core_pwr_en = 1'b0;
         s_d.sys_rst_b = 1'b0;
         s_d.otp_shutdown = 1'b1;
      end

      if (go_reset)
      begin
         s_d.st = ST_RESET; // RULE_06
         s_d.cnt = '0;
         s_d.sys_rst_b = 1'b0;
         s_d.core_pwr_en = 1'b0;
         s_d.straps_valid = 1'b0; // RULE_12
         s_d.test_mode = 1'b0;
         s_d.supply_opt1 = 1'b0;
         s_d.download_boot = 1'b0;
         s_d.boot_done = 1'b0;
         s_d.otp_shutdown = 1'b0;
      end

      // Thermal events
      ev = '0;
      ev[INT_HIGH] = hi_now && !s_q.hi_prev; // RULE_08
      ev[INT_LOW] = lo_now && !s_q.lo_prev; // RULE_09
      ev[INT_OTP] = otp_now;
      s_d.hi_prev = hi_now;
      s_d.lo_prev = lo_now;

      // APB: one wait state, so the read mux settles before pready
      s_d.pready = setup;
      s_d.pslverr = setup && !is_mapped(paddr);
      if (setup)
         s_d.prdata = pwrite ? '0 : rdv;

      if (wr)
      begin
         case (paddr)
            OFS_CTRL:
            begin
               // One write per unlock; a locked write changes nothing
               if (s_q.unlocked)
               begin
                  s_d.therm_en = pwdata[CTRL_THERM_EN]; // RULE_11
                  s_d.otp_en = pwdata[CTRL_OTP_EN];
               end
               s_d.unlocked = 1'b0;
            end
            OFS_KEY: s_d.unlocked = (pwdata[7:0] == UNLOCK_KEY); // RULE_11
            OFS_DEBOUNCE:
               s_d.deb_code = (pwdata[DEB_CODE_W-1:0] > DEB_CODE_MAX) ?
                              DEB_CODE_MAX : pwdata[DEB_CODE_W-1:0]; // RULE_06
            OFS_THR_HIGH: s_d.thr_high = pwdata[TEMP_W-1:0];
            OFS_THR_LOW: s_d.thr_low = pwdata[TEMP_W-1:0];
            OFS_THR_OTP: s_d.thr_otp = pwdata[TEMP_W-1:0];
            OFS_INT_MASK: s_d.int_mask = pwdata[INT_W-1:0];
            default: s_d.unlocked = s_q.unlocked;
         endcase
      end

      // Set wins over a simultaneous write-one-to-clear
      s_d.int_stat = s_q.int_stat;
      if (wr && (paddr == OFS_INT_STAT))
         s_d.int_stat = s_q.int_stat & ~pwdata[INT_W-1:0];
      s_d.int_stat = s_d.int_stat | ev;
      s_d.irq = |(s_d.int_stat & s_d.int_mask);
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s_q <= '0;
         s_q.deb_code <= DEB_CODE_MAX;
         s_q.thr_high <= THR_HIGH_RST;
         s_q.thr_low <= THR_LOW_RST;
         s_q.thr_otp <= THR_OTP_RST;
      end
      else
         s_q <= s_d;
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign irq = s_q.irq;
   assign sys_rst_b = s_q.sys_rst_b;
   assign core_pwr_en = s_q.core_pwr_en;
   assign test_mode = s_q.test_mode;
   assign supply_opt1 = s_q.supply_opt1;
   assign download_boot = s_q.download_boot;
   assign boot_done = s_q.boot_done;
   assign otp_shutdown = s_q.otp_shutdown;

   // ==========================================================
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   sequence s_released;
      $rose(s_q.sys_rst_b);
   endsequence

   sequence s_straps_taken;
      $rose(s_q.straps_valid);
   endsequence

   property p_release;
      s_released |-> $past(por_ok && en_ok && !go_reset);
   endproperty
   a_release: assert property (p_release) else $error("reset released early"); // RULE_01

   property p_test_strap_time;
      s_released |-> ##[1:110] (s_q.straps_valid || !s_q.sys_rst_b);
   endproperty
   a_test_strap_time: assert property (p_test_strap_time) else $error("straps late"); // RULE_02

   property p_test_strap_val;
      s_straps_taken |-> s_q.test_mode == !$past(s_q.strap_s2[0]);
   endproperty
   a_test_strap_val: assert property (p_test_strap_val) else $error("test mode wrong"); // RULE_02

   property p_supply_strap;
      s_straps_taken |-> s_q.supply_opt1 == $past(s_q.strap_s2[1]);
   endproperty
   a_supply_strap: assert property (p_supply_strap) else $error("supply option wrong"); // RULE_03

   property p_core_start;
      $rose(s_q.core_pwr_en) |-> s_q.straps_valid && ($past(s_q.st) == ST_STRAP);
   endproperty
   a_core_start: assert property (p_core_start) else $error("core power out of order"); // RULE_04

   property p_dl_strap;
      $rose(s_q.st == ST_DL_STRAP) |-> ##[1:110] (s_q.boot_done || !s_q.sys_rst_b);
   endproperty
   a_dl_strap: assert property (p_dl_strap) else $error("download strap late"); // RULE_05

   property p_dl_val;
      $rose(s_q.boot_done) |-> s_q.download_boot == !$past(s_q.strap_s2[2]);
   endproperty
   a_dl_val: assert property (p_dl_val) else $error("download boot wrong"); // RULE_05

   property p_deb_reset;
      deb_bus.held_low |=> !s_q.sys_rst_b && (s_q.st == ST_RESET);
   endproperty
   a_deb_reset: assert property (p_deb_reset) else $error("debounced reset ignored"); // RULE_06

   property p_high_irq;
      (hi_now && !s_q.hi_prev) |=> s_q.int_stat[INT_HIGH] ##1 (s_q.irq == s_q.int_mask[INT_HIGH] || $past(wr));
   endproperty
   a_high_irq: assert property (p_high_irq) else $error("high event lost"); // RULE_08

   property p_low_irq;
      (lo_now && !s_q.lo_prev) |=> s_q.int_stat[INT_LOW];
   endproperty
   a_low_irq: assert property (p_low_irq) else $error("low event lost"); // RULE_09

   property p_otp;
      otp_now |=> !s_q.core_pwr_en && s_q.otp_shutdown && (s_q.st == ST_OTP_OFF);
   endproperty
   a_otp: assert property (p_otp) else $error("no protection shutdown"); // RULE_10

   property p_lock;
      (wr && (paddr == OFS_CTRL) && !s_q.unlocked) |=> $stable(s_q.therm_en) && $stable(s_q.otp_en);
   endproperty
   a_lock: assert property (p_lock) else $error("locked enable changed"); // RULE_11

   property p_strap_hold;
      (s_q.straps_valid && $past(s_q.straps_valid)) |-> $stable(s_q.test_mode) && $stable(s_q.supply_opt1);
   endproperty
   a_strap_hold: assert property (p_strap_hold) else $error("strap changed in cycle"); // RULE_12
endmodule : power_on_reset_boot_straps

// [verification/board_model.sv]
`timescale 1ns/1ps
// ==========================================
// Board supplies, reset source and straps
module board_model
   import pwr_seq_pkg::*;
(
   input wire logic core_clk,
   input wire logic supply_on,
   input wire logic en_on,
   input wire logic [15:0] low_cyc,
   input wire logic [2:0] strap_cfg,
   output logic supply_above_por,
   output logic chip_en,
   output logic [2:0] straps
);
   logic [15:0] low_q;
   // Pull resistors keep straps at a firm level
   assign straps = strap_cfg;
   always @(posedge core_clk)
   begin
      supply_above_por <= supply_on;
      // Low time stretched by low_cyc cycles after en_on returns high
      if (!en_on)
      begin
         low_q <= low_cyc;
      end
      else if (low_q != 16'h0000)
      begin
         low_q <= low_q - 16'h0001;
      end
      chip_en <= en_on && (low_q == 16'h0000);
   end
endmodule : board_model

// [verification/power_on_reset_boot_straps_tb_top.sv]
`timescale 1ns/1ps
module power_on_reset_boot_straps_tb_top
   import pwr_seq_pkg::*;
   ;
   localparam int C1 = 50;
   localparam int C2 = 70;
   typedef struct packed {
      logic [2:0] pins;
      logic sup_first;
      logic [2:0] exp;
   } row_t;
   // Expected {download_boot, supply_opt1, test_mode}
   localparam row_t ROWS [8] = '{
      '{3'h0, 1'b1, 3'h5}, '{3'h1, 1'b0, 3'h4}, '{3'h2, 1'b1, 3'h7}, '{3'h3, 1'b0, 3'h6},
      '{3'h4, 1'b1, 3'h1}, '{3'h5, 1'b0, 3'h0}, '{3'h6, 1'b1, 3'h3}, '{3'h7, 1'b0, 3'h2}};
   localparam logic [ADDR_W-1:0] RADR [7] = '{OFS_CTRL, OFS_DEBOUNCE, OFS_THR_HIGH,
      OFS_THR_LOW, OFS_THR_OTP, OFS_INT_STAT, OFS_INT_MASK};
   localparam logic [31:0] RVAL [7] = '{32'h0, 32'h10, 32'(THR_HIGH_RST), 32'(THR_LOW_RST),
      32'(THR_OTP_RST), 32'h0, 32'h0};
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic supply_on = 1'b0;
   logic en_on = 1'b0;
   logic [15:0] low_cyc = 16'h04B0;
   logic [2:0] strap_cfg = 3'h7;
   logic [TEMP_W-1:0] temp_code = 8'h50;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rdata;
   logic [2:0] straps;
   logic supply_above_por, chip_en, pready, pslverr, rerr, irq, sys_rst_b, core_pwr_en;
   logic test_mode, supply_opt1, download_boot, boot_done, otp_shutdown;
   int failures = 0;
   int checks = 0;

   always #50 core_clk = ~core_clk;

   board_model board (.core_clk(core_clk), .supply_on(supply_on), .en_on(en_on),
      .low_cyc(low_cyc), .strap_cfg(strap_cfg), .supply_above_por(supply_above_por),
      .chip_en(chip_en), .straps(straps));

   // Shortened counts keep the run brief
   power_on_reset_boot_straps #(.CORE1_CYC(C1), .CORE2_CYC(C2), .DEB_STEP_CYC(4)) DUT (
      .core_clk(core_clk), .rst_b(rst_b), .supply_above_por(supply_above_por),
      .chip_en(chip_en), .test_mode_strap(straps[0]), .supply_option_strap(straps[1]),
      .download_disable_strap(straps[2]), .temp_code(temp_code), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .sys_rst_b(sys_rst_b),
      .core_pwr_en(core_pwr_en), .test_mode(test_mode), .supply_opt1(supply_opt1),
      .download_boot(download_boot), .boot_done(boot_done), .otp_shutdown(otp_shutdown));

   // ==========================================
   // Helpers
   task automatic finish_test;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
      begin
         $display("Simulation passed");
      end
      else
      begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
      int n;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rdata = prdata;
      rerr = pslverr;
      if (n >= 20) failures++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic idle(input int n);
      repeat (n) @(negedge core_clk);
   endtask : idle

   task automatic wait_boot;
      int n;
      n = 0;
      while (boot_done !== 1'b1 && n < 3000)
      begin
         @(negedge core_clk);
         n++;
      end
   endtask : wait_boot

   task automatic boot_row(input row_t r);
      int n;
      @(posedge core_clk);
      supply_on <= 1'b0;
      en_on <= 1'b0;
      strap_cfg <= r.pins;
      idle(10);
      check(32'(sys_rst_b), 32'h0);
      @(posedge core_clk);
      supply_on <= r.sup_first;
      en_on <= !r.sup_first;
      idle(1300);
      check(32'(sys_rst_b), 32'h0);
      @(posedge core_clk);
      supply_on <= 1'b1;
      en_on <= 1'b1;
      n = 0;
      while (sys_rst_b !== 1'b1 && n < 1500)
      begin
         @(negedge core_clk);
         n++;
      end
      n = 0;
      while (core_pwr_en !== 1'b1 && n < 40000)
      begin
         @(negedge core_clk);
         n++;
      end
      check(32'(n), 32'd100);
      check(32'({supply_opt1, test_mode}), 32'(r.exp[1:0]));
      n = 0;
      while (boot_done !== 1'b1 && n < 2000)
      begin
         @(negedge core_clk);
         n++;
      end
      check(32'(n), 32'((r.pins[1] ? C1 : C2) + 100));
      @(posedge core_clk);
      strap_cfg <= ~r.pins;
      idle(20);
      check(32'({download_boot, supply_opt1, test_mode}), 32'(r.exp));
      apb(1'b0, OFS_STATUS, 32'h0);
      check({24'h0, rdata[7], 4'h0, rdata[2:0]}, {24'h0, 1'b1, 4'h0, r.exp});
   endtask : boot_row

   // ==========================================
   // Main sequence
   initial
   begin
      repeat (2) @(posedge core_clk);
      rst_b <= 1'b1;
      idle(2);
      check(32'({sys_rst_b, irq, core_pwr_en}), 32'h0);
      for (int i = 0; i < 7; i++)
      begin
         apb(1'b0, RADR[i], 32'h0);
         check(rdata, RVAL[i]);
      end
      apb(1'b0, 12'h100, 32'h0);
      check({rdata[30:0], rerr}, 32'h1);
      apb(1'b1, OFS_CTRL, 32'h3);
      apb(1'b0, OFS_CTRL, 32'h0);
      check(rdata, 32'h0);
      apb(1'b1, OFS_DEBOUNCE, 32'h1);
      for (int i = 0; i < 8; i++)
      begin
         boot_row(ROWS[i]);
      end
      // Short dip below the 5-cycle debounce, against the source's minimum
      low_cyc <= 16'h0002;
      en_on <= 1'b0;
      @(posedge core_clk);
      en_on <= 1'b1;
      idle(20);
      check(32'(sys_rst_b), 32'h1);
      @(posedge core_clk);
      low_cyc <= 16'h000A;
      en_on <= 1'b0;
      @(posedge core_clk);
      en_on <= 1'b1;
      idle(10);
      check(32'({sys_rst_b, core_pwr_en, boot_done}), 32'h0);
      wait_boot();
      check(32'(boot_done), 32'h1);
      apb(1'b1, OFS_THR_HIGH, 32'h80);
      apb(1'b1, OFS_THR_LOW, 32'h20);
      apb(1'b1, OFS_THR_OTP, 32'hC0);
      apb(1'b1, OFS_INT_MASK, 32'h7);
      apb(1'b1, OFS_KEY, 32'(UNLOCK_KEY));
      apb(1'b1, OFS_CTRL, 32'h3);
      apb(1'b0, OFS_CTRL, 32'h0);
      check(rdata, 32'h3);
      @(posedge core_clk);
      temp_code <= 8'h90;
      idle(8);
      check(32'(irq), 32'h1);
      apb(1'b0, OFS_INT_STAT, 32'h0);
      check(rdata, 32'h1);
      apb(1'b1, OFS_INT_STAT, 32'h1);
      idle(3);
      check(32'(irq), 32'h0);
      apb(1'b1, OFS_INT_MASK, 32'h5);
      temp_code <= 8'h10;
      idle(8);
      check(32'(irq), 32'h0);
      apb(1'b0, OFS_INT_STAT, 32'h0);
      check(rdata, 32'h2);
      apb(1'b1, OFS_INT_MASK, 32'h7);
      idle(3);
      check(32'(irq), 32'h1);
      apb(1'b1, OFS_INT_STAT, 32'h2);
      idle(3);
      check(32'(irq), 32'h0);
      @(posedge core_clk);
      temp_code <= 8'hD0;
      idle(8);
      check(32'({otp_shutdown, sys_rst_b, core_pwr_en, irq}), 32'h9);
      finish_test();
   end

   initial
   begin
      repeat (40000) @(posedge core_clk);
      failures++;
      finish_test();
   end
endmodule : power_on_reset_boot_straps_tb_top
